// file: hdl/focvr_pkg.sv
// Package: register map, constants and carrier types of the FOC result bank
package focvr_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [15:0] A_Q_VOLT_OUT = 16'h40BA;
  localparam logic [15:0] A_D_CUR = 16'h40BC;
  localparam logic [15:0] A_Q_CUR = 16'h40BE;
  localparam logic [15:0] A_BETA_CUR = 16'h40C0;
  localparam logic [15:0] A_BETA_VOLT = 16'h40C2;
  localparam logic [15:0] A_D_VOLT_COMP = 16'h40C2;
  localparam logic [15:0] A_ALPHA_VOLT = 16'h40C4;
  localparam logic [15:0] A_Q_VOLT_COMP = 16'h40C4;
  localparam logic [15:0] A_PHASE_C = 16'h40C6;
  localparam logic [15:0] A_PHASE_B = 16'h40C8;
  localparam logic [15:0] A_PHASE_A = 16'h40CA;
  localparam logic [15:0] A_OUT_ANGLE = 16'h40CC;
  localparam logic [15:0] A_EST_ANGLE = 16'h40CE;
  localparam logic [15:0] A_ALPHA_BEMF = 16'h40D0;
  localparam logic [15:0] A_BETA_BEMF = 16'h40D2;
  localparam logic [15:0] A_EST_SPEED = 16'h40D4;
  localparam logic [15:0] A_Q_OVERFLOW = 16'h40D6;
  localparam logic [15:0] A_FREQ_COEFF = 16'h40D6;
  localparam logic [15:0] A_MOTOR_POWER = 16'h40D8;
  localparam logic [15:0] A_SPEED_FILT = 16'h40D8;
  localparam logic [15:0] A_PHASE_A_PEAK = 16'h40DA;

  // ----------------------------------------------------------------
  // Reset values, field positions, counts
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam int SPEED_FILT_LSB = 0;
  localparam int SPEED_FILT_MSB = 7;
  localparam int LPF_FRAC = 15;
  localparam int FG_SHIFT = 8;
  localparam logic [5:0] FG_DIV_STEPS = 6'h20;
  localparam logic [15:0] FG_SAT = 16'hFFFF;

  // Software load strobes towards the engine
  localparam int LD_Q_VOLT = 0;
  localparam int LD_OUT_ANGLE = 1;
  localparam int LD_EST_ANGLE = 2;
  localparam int LD_EST_SPEED = 3;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] d_pi;
    logic [15:0] q_pi;
    logic [15:0] d_cur;
    logic [15:0] q_cur;
    logic [15:0] beta_cur;
    logic [15:0] beta_volt;
    logic [15:0] alpha_volt;
    logic [15:0] phase_a;
    logic [15:0] phase_b;
    logic [15:0] est_angle;
    logic [15:0] angle_comp;
    logic [15:0] alpha_bemf;
    logic [15:0] beta_bemf;
    logic [15:0] est_speed;
    logic [15:0] q_limit;
    logic [15:0] power;
  } focvr_eng_t;

  typedef struct packed {
    logic [15:0] d_volt_fwd;
    logic [15:0] q_volt_fwd;
    logic [15:0] phase_c;
    logic [3:0] ld_sel;
    logic [15:0] ld_val;
    logic [15:0] filt_speed;
    logic [15:0] timer4_reload;
    logic [15:0] timer4_compare;
    logic timer4_load;
    logic fg_overflow;
  } focvr_drv_t;

  typedef enum logic {FG_IDLE, FG_DIV} focvr_fg_t;

endpackage

// file: hdl/focvr_regs.sv
// FOC result register bank with compensation, speed filter and FG period
//
// How it works
// [RULE_01] q-axis PI result register is signed 16-bit, readable and writable.
// [RULE_02] d and q currents are read-only, hardware updated, writes ignored.
// [RULE_03] Beta-axis current from the transform is read-only signed 16-bit.
// [RULE_04] Alpha and beta output voltages are read-only signed 16-bit.
// [RULE_05] Write-only d compensation added to d PI output; shares beta addr.
// [RULE_06] Write-only q compensation added to q PI output; shares alpha addr.
// [RULE_07] Phase A and B samples read-only; phase C location write-only.
// [RULE_08] Output angle full signed range spans minus to plus half turn.
// [RULE_09] Estimator angle reads raw estimate; write loads starting angle.
// [RULE_10] Alpha and beta back-EMF estimates are read-only signed 16-bit.
// [RULE_11] Estimator speed is a signed 16-bit read/write register.
// [RULE_12] q overflow equals q PI output minus q upper limit.
// [RULE_13] Each PWM cycle FG period goes to timer reload, half to compare.
// [RULE_14] Zero FG coefficient disables period calculation and timer updates.
// [RULE_15] Software adjusts timer prescale when the FG result overflows.
// [RULE_16] Motor power read-only signed; negative value means error.
// [RULE_17] 8-bit write-only speed filter coefficient, code over 32768.
// [RULE_18] Peak A-phase current held until peak clear; no auto clear.
// [RULE_19] Software trusts the peak only after one electrical cycle.
// [RULE_20] Filtered speed is low-passed once per PWM cycle.
// [RULE_21] Shared addresses: reads give result, writes touch only parameter.
`timescale 1ns/10ps
module focvr_regs (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Register port
  input wire logic [15:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  // Engine side
  input wire logic pwm_tick_i,
  input wire logic peak_clear_i,
  input wire focvr_pkg::focvr_eng_t eng_i,
  output focvr_pkg::focvr_drv_t drv_o
);

  typedef struct packed {
    logic [15:0] rdata;
    logic [15:0] q_volt_out;
    logic [15:0] d_cur;
    logic [15:0] q_cur;
    logic [15:0] beta_cur;
    logic [15:0] beta_volt;
    logic [15:0] alpha_volt;
    logic [15:0] phase_a;
    logic [15:0] phase_b;
    logic [15:0] out_angle;
    logic [15:0] est_angle;
    logic [15:0] alpha_bemf;
    logic [15:0] beta_bemf;
    logic [15:0] est_speed;
    logic [15:0] q_overflow;
    logic [15:0] power;
    logic [15:0] phase_a_peak;
    logic [15:0] d_comp;
    logic [15:0] q_comp;
    logic [15:0] freq_coeff;
    logic [7:0] speed_coeff;
    logic [31:0] lpf_acc;
    focvr_pkg::focvr_fg_t fg;
    logic [16:0] div_rem;
    logic [31:0] div_quo;
    logic [15:0] div_den;
    logic [5:0] div_cnt;
    focvr_pkg::focvr_drv_t drv;
  } focvr_st_t;

  focvr_st_t st_r;
  focvr_st_t st_nxt;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] sat16(input logic [16:0] v);
    logic [15:0] r;
    r = v[15:0];
    if (v[16] != v[15]) begin
      r = v[16] ? 16'h8000 : 16'h7FFF;
    end
    return r;
  endfunction

  function automatic logic [16:0] sext(input logic [15:0] v);
    return {v[15], v};
  endfunction

  logic [16:0] d_sum;
  logic [16:0] q_sum;
  logic [16:0] q_diff;
  logic [15:0] filt;
  logic [16:0] spd_delta;
  logic [25:0] spd_prod;
  logic [16:0] div_shift;
  logic [17:0] div_trial;
  logic [15:0] peak_base;
  logic [16:0] abs_filt;

  always_comb begin
    d_sum = sext(eng_i.d_pi) + sext(st_r.d_comp);
    q_sum = sext(st_r.q_volt_out) + sext(st_r.q_comp);
    q_diff = sext(eng_i.q_pi) - sext(eng_i.q_limit);
    filt = st_r.lpf_acc[focvr_pkg::LPF_FRAC +: 16];
    spd_delta = sext(st_r.est_speed) - sext(filt);
    spd_prod = 26'($signed(spd_delta) * $signed({1'b0, st_r.speed_coeff}));
    div_shift = {st_r.div_rem[15:0], st_r.div_quo[31]};
    div_trial = {1'b0, div_shift} - {2'b00, st_r.div_den};
    peak_base = peak_clear_i ? focvr_pkg::RST_WORD : st_r.phase_a_peak;
    abs_filt = filt[15] ? 17'(-sext(filt)) : sext(filt);
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.rdata = focvr_pkg::RST_WORD;
    st_nxt.drv.ld_sel = 4'h0;
    st_nxt.drv.timer4_load = 1'b0;

    // Compensated voltages towards the modulator
    st_nxt.drv.d_volt_fwd = sat16(d_sum); // RULE_05
    st_nxt.drv.q_volt_fwd = sat16(q_sum); // RULE_06
    st_nxt.drv.filt_speed = filt; // RULE_20

    // Results captured once per PWM cycle
    if (pwm_tick_i) begin
      st_nxt.q_volt_out = eng_i.q_pi; // RULE_01
      st_nxt.d_cur = eng_i.d_cur; // RULE_02
      st_nxt.q_cur = eng_i.q_cur; // RULE_02
      st_nxt.beta_cur = eng_i.beta_cur; // RULE_03
      st_nxt.beta_volt = eng_i.beta_volt; // RULE_04
      st_nxt.alpha_volt = eng_i.alpha_volt; // RULE_04
      st_nxt.phase_a = eng_i.phase_a; // RULE_07
      st_nxt.phase_b = eng_i.phase_b; // RULE_07
      st_nxt.est_angle = eng_i.est_angle; // RULE_09
      // Wraps on purpose: angles are modulo one turn
      st_nxt.out_angle = eng_i.est_angle + eng_i.angle_comp; // RULE_08
      st_nxt.alpha_bemf = eng_i.alpha_bemf; // RULE_10
      st_nxt.beta_bemf = eng_i.beta_bemf; // RULE_10
      st_nxt.est_speed = eng_i.est_speed; // RULE_11
      st_nxt.q_overflow = sat16(q_diff); // RULE_12
      st_nxt.power = eng_i.power; // RULE_16
      st_nxt.lpf_acc = st_r.lpf_acc + {{6{spd_prod[25]}}, spd_prod}; // RULE_17
    end

    // Peak tracker; a new maximum beats a clear in the same cycle
    st_nxt.phase_a_peak = peak_base; // RULE_18
    if (pwm_tick_i && ($signed(eng_i.phase_a) > $signed(peak_base))) begin
      st_nxt.phase_a_peak = eng_i.phase_a; // RULE_18
    end

    // Software writes; read-only results ignore them
    if (wr_i) begin
      case (addr_i)
        focvr_pkg::A_Q_VOLT_OUT: begin
          st_nxt.q_volt_out = wdata_i; // RULE_01
          st_nxt.drv.ld_sel[focvr_pkg::LD_Q_VOLT] = 1'b1;
          st_nxt.drv.ld_val = wdata_i;
        end
        focvr_pkg::A_D_VOLT_COMP: begin
          st_nxt.d_comp = wdata_i; // RULE_05 RULE_21
        end
        focvr_pkg::A_Q_VOLT_COMP: begin
          st_nxt.q_comp = wdata_i; // RULE_06 RULE_21
        end
        focvr_pkg::A_PHASE_C: begin
          st_nxt.drv.phase_c = wdata_i; // RULE_07
        end
        focvr_pkg::A_OUT_ANGLE: begin
          st_nxt.out_angle = wdata_i; // RULE_08
          st_nxt.drv.ld_sel[focvr_pkg::LD_OUT_ANGLE] = 1'b1;
          st_nxt.drv.ld_val = wdata_i;
        end
        focvr_pkg::A_EST_ANGLE: begin
          // Start angle goes out, readback stays the estimate
          st_nxt.drv.ld_sel[focvr_pkg::LD_EST_ANGLE] = 1'b1; // RULE_09
          st_nxt.drv.ld_val = wdata_i;
        end
        focvr_pkg::A_EST_SPEED: begin
          st_nxt.est_speed = wdata_i; // RULE_11
          st_nxt.drv.ld_sel[focvr_pkg::LD_EST_SPEED] = 1'b1;
          st_nxt.drv.ld_val = wdata_i;
        end
        focvr_pkg::A_FREQ_COEFF: begin
          st_nxt.freq_coeff = wdata_i; // RULE_13 RULE_21
        end
        focvr_pkg::A_SPEED_FILT: begin
          st_nxt.speed_coeff = // RULE_17 RULE_21
            wdata_i[focvr_pkg::SPEED_FILT_MSB:focvr_pkg::SPEED_FILT_LSB];
        end
        default: begin
        end
      endcase
    end

    // Read port; shared addresses return the result
    if (rd_i) begin
      case (addr_i)
        focvr_pkg::A_Q_VOLT_OUT: begin
          st_nxt.rdata = st_r.q_volt_out; // RULE_01
        end
        focvr_pkg::A_D_CUR: begin
          st_nxt.rdata = st_r.d_cur; // RULE_02
        end
        focvr_pkg::A_Q_CUR: begin
          st_nxt.rdata = st_r.q_cur; // RULE_02
        end
        focvr_pkg::A_BETA_CUR: begin
          st_nxt.rdata = st_r.beta_cur; // RULE_03
        end
        focvr_pkg::A_BETA_VOLT: begin
          st_nxt.rdata = st_r.beta_volt; // RULE_04 RULE_21
        end
        focvr_pkg::A_ALPHA_VOLT: begin
          st_nxt.rdata = st_r.alpha_volt; // RULE_04 RULE_21
        end
        focvr_pkg::A_PHASE_B: begin
          st_nxt.rdata = st_r.phase_b; // RULE_07
        end
        focvr_pkg::A_PHASE_A: begin
          st_nxt.rdata = st_r.phase_a; // RULE_07
        end
        focvr_pkg::A_OUT_ANGLE: begin
          st_nxt.rdata = st_r.out_angle; // RULE_08
        end
        focvr_pkg::A_EST_ANGLE: begin
          st_nxt.rdata = st_r.est_angle; // RULE_09
        end
        focvr_pkg::A_ALPHA_BEMF: begin
          st_nxt.rdata = st_r.alpha_bemf; // RULE_10
        end
        focvr_pkg::A_BETA_BEMF: begin
          st_nxt.rdata = st_r.beta_bemf; // RULE_10
        end
        focvr_pkg::A_EST_SPEED: begin
          st_nxt.rdata = st_r.est_speed; // RULE_11
        end
        focvr_pkg::A_Q_OVERFLOW: begin
          st_nxt.rdata = st_r.q_overflow; // RULE_12 RULE_21
        end
        focvr_pkg::A_MOTOR_POWER: begin
          st_nxt.rdata = st_r.power; // RULE_16 RULE_21
        end
        focvr_pkg::A_PHASE_A_PEAK: begin
          st_nxt.rdata = st_r.phase_a_peak; // RULE_18
        end
        default: begin
          st_nxt.rdata = focvr_pkg::RST_WORD;
        end
      endcase
    end

    // FG period: restoring divide of the shifted coefficient by |filtered speed|
    case (st_r.fg)
      focvr_pkg::FG_IDLE: begin
        if (pwm_tick_i && (st_r.freq_coeff != focvr_pkg::RST_WORD)) begin
          st_nxt.fg = focvr_pkg::FG_DIV; // RULE_14
          st_nxt.div_quo =
            {16'h0000, st_r.freq_coeff} << focvr_pkg::FG_SHIFT;
          st_nxt.div_rem = 17'h00000;
          st_nxt.div_den = abs_filt[15:0];
          st_nxt.div_cnt = focvr_pkg::FG_DIV_STEPS;
        end
      end
      focvr_pkg::FG_DIV: begin
        if (st_r.div_cnt == 6'h00) begin
          st_nxt.fg = focvr_pkg::FG_IDLE;
          st_nxt.drv.timer4_load = 1'b1; // RULE_13
          if (st_r.div_quo[31:16] != 16'h0000) begin
            // Too wide: saturate and flag it for a prescale change
            st_nxt.drv.timer4_reload = focvr_pkg::FG_SAT;
            st_nxt.drv.fg_overflow = 1'b1;
          end else begin
            st_nxt.drv.timer4_reload = st_r.div_quo[15:0];
            st_nxt.drv.fg_overflow = 1'b0;
          end
          st_nxt.drv.timer4_compare = {1'b0, st_nxt.drv.timer4_reload[15:1]};
        end else begin
          st_nxt.div_cnt = st_r.div_cnt - 6'h01;
          if (!div_trial[17]) begin
            st_nxt.div_rem = div_trial[16:0];
            st_nxt.div_quo = {st_r.div_quo[30:0], 1'b1};
          end else begin
            st_nxt.div_rem = div_shift;
            st_nxt.div_quo = {st_r.div_quo[30:0], 1'b0};
          end
        end
      end
      default: begin
        st_nxt.fg = focvr_pkg::FG_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata_o = st_r.rdata;
  assign drv_o = st_r.drv;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_ro_stable;
    @(posedge clk_i) disable iff (reset_i)
      !pwm_tick_i |=> $stable({st_r.d_cur, st_r.q_cur, st_r.beta_cur});
  endproperty
  a_ro_stable: assert property (p_ro_stable) // RULE_02
    else $error("read-only result changed without a PWM tick");

  property p_shared_read;
    @(posedge clk_i) disable iff (reset_i)
      (rd_i && (addr_i == focvr_pkg::A_BETA_VOLT))
        |=> (rdata_o == $past(st_r.beta_volt));
  endproperty
  a_shared_read: assert property (p_shared_read) // RULE_21
    else $error("shared address did not return the result");

  property p_q_over_sign;
    @(posedge clk_i) disable iff (reset_i)
      pwm_tick_i |=> (st_r.q_overflow[15] ==
        ($signed($past(eng_i.q_pi)) < $signed($past(eng_i.q_limit))));
  endproperty
  a_q_over_sign: assert property (p_q_over_sign) // RULE_12
    else $error("q overflow sign disagrees with limit");

  property p_fg_idle;
    @(posedge clk_i) disable iff (reset_i)
      ((st_r.freq_coeff == 16'h0000) && (st_r.fg == focvr_pkg::FG_IDLE))
        |=> (st_r.fg == focvr_pkg::FG_IDLE);
  endproperty
  a_fg_idle: assert property (p_fg_idle) // RULE_14
    else $error("FG calculation started with zero coefficient");

  property p_fg_half;
    @(posedge clk_i) disable iff (reset_i)
      drv_o.timer4_load
        |-> (drv_o.timer4_compare == {1'b0, drv_o.timer4_reload[15:1]});
  endproperty
  a_fg_half: assert property (p_fg_half) // RULE_13
    else $error("timer compare is not half the reload");

  property p_peak_mono;
    @(posedge clk_i) disable iff (reset_i)
      !peak_clear_i
        |=> ($signed(st_r.phase_a_peak) >= $signed($past(st_r.phase_a_peak)));
  endproperty
  a_peak_mono: assert property (p_peak_mono) // RULE_18
    else $error("peak fell without a clear");

  property p_peak_clear;
    @(posedge clk_i) disable iff (reset_i)
      (peak_clear_i && !pwm_tick_i) |=> (st_r.phase_a_peak == 16'h0000);
  endproperty
  a_peak_clear: assert property (p_peak_clear) // RULE_18
    else $error("peak not cleared");

  property p_ld_onehot;
    @(posedge clk_i) disable iff (reset_i)
      $onehot0(drv_o.ld_sel);
  endproperty
  a_ld_onehot: assert property (p_ld_onehot) // RULE_09
    else $error("more than one load strobe");

  property p_est_load;
    @(posedge clk_i) disable iff (reset_i)
      (wr_i && (addr_i == focvr_pkg::A_EST_ANGLE))
        |=> (drv_o.ld_sel[2] && (drv_o.ld_val == $past(wdata_i)));
  endproperty
  a_est_load: assert property (p_est_load) // RULE_09
    else $error("start angle not passed to the estimator");

  // Main scenarios
  c_fg_load: cover property (@(posedge clk_i) disable iff (reset_i)
    drv_o.timer4_load);
  c_fg_sat: cover property (@(posedge clk_i) disable iff (reset_i)
    drv_o.timer4_load && drv_o.fg_overflow);
  c_peak_clear: cover property (@(posedge clk_i) disable iff (reset_i)
    peak_clear_i && (st_r.phase_a_peak != 16'h0000));

endmodule

// file: dv/focvr_regs_tb.sv
// Self-checking testbench of the FOC result register bank
`timescale 1ns/10ps
module focvr_regs_tb;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic pwm_tick_i = 1'b0;
  logic peak_clear_i = 1'b0;
  logic [15:0] addr_i = 16'h0000;
  logic [15:0] wdata_i = 16'h0000;
  logic [15:0] rdata_o;
  focvr_pkg::focvr_eng_t eng_i = '0;
  focvr_pkg::focvr_drv_t drv_o;
  int err_count = 0;
  int compares = 0;
  focvr_regs i_dut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .pwm_tick_i(pwm_tick_i), .peak_clear_i(peak_clear_i), .eng_i(eng_i),
    .drv_o(drv_o));
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task chk(string nm, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(logic [15:0] a, logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task rdc(string nm, logic [15:0] a, logic [15:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(nm, rdata_o, e);
  endtask
  task tick();
    @(posedge clk_i);
    pwm_tick_i <= 1'b1;
    @(posedge clk_i);
    pwm_tick_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  task wait_load();
    int n;
    n = 0;
    while (n < 60 && drv_o.timer4_load !== 1'b1) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 60) begin
      err_count++;
      $display("[ERR] timer4_load expected 1 seen 0");
      give_verdict();
    end
  endtask
  task no_load(string nm);
    int n;
    n = 0;
    repeat (40) begin
      @(posedge clk_i);
      if (drv_o.timer4_load !== 1'b0) n++;
    end
    chk(nm, 16'(n), 16'h0000);
  endtask
  task give_verdict();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_ro();
    eng_i <= {16'h0010, 16'h0300, 16'h8000, 16'h7FFF, 16'h1234, 16'hA5A5,
      16'h5A5A, 16'h0100, 16'hFEDC, 16'h2000, 16'h0000, 16'h1111,
      16'hEEEE, 16'h0000, 16'h0100, 16'h8001};
    tick();
    wr(focvr_pkg::A_D_CUR, 16'h0000);
    rdc("d_cur", focvr_pkg::A_D_CUR, 16'h8000);
    rdc("q_cur", focvr_pkg::A_Q_CUR, 16'h7FFF);
    rdc("beta_cur", focvr_pkg::A_BETA_CUR, 16'h1234);
    rdc("phase_b", focvr_pkg::A_PHASE_B, 16'hFEDC);
    wr(focvr_pkg::A_EST_ANGLE, 16'h4000);
    rdc("est_angle", focvr_pkg::A_EST_ANGLE, 16'h2000);
    chk("ld_val", drv_o.ld_val, 16'h4000);
    rdc("phase_a", focvr_pkg::A_PHASE_A, 16'h0100);
    rdc("out_angle", focvr_pkg::A_OUT_ANGLE, 16'h2000);
    rdc("bemf_a", focvr_pkg::A_ALPHA_BEMF, 16'h1111);
    rdc("bemf_b", focvr_pkg::A_BETA_BEMF, 16'hEEEE);
    rdc("q_over", focvr_pkg::A_Q_OVERFLOW, 16'h0200);
    rdc("power", focvr_pkg::A_MOTOR_POWER, 16'h8001);
    $display("read-only test done");
  endtask
  task t_comp();
    wr(focvr_pkg::A_D_VOLT_COMP, 16'h0005);
    wr(focvr_pkg::A_Q_VOLT_COMP, 16'hFFFE);
    wr(focvr_pkg::A_PHASE_C, 16'h4321);
    tick();
    chk("d_fwd", drv_o.d_volt_fwd, 16'h0015);
    chk("q_fwd", drv_o.q_volt_fwd, 16'h02FE);
    chk("phase_c", drv_o.phase_c, 16'h4321);
    rdc("beta_volt", focvr_pkg::A_BETA_VOLT, 16'hA5A5);
    rdc("alpha_volt", focvr_pkg::A_ALPHA_VOLT, 16'h5A5A);
    wr(focvr_pkg::A_Q_VOLT_OUT, 16'h8000);
    rdc("q_volt_out", focvr_pkg::A_Q_VOLT_OUT, 16'h8000);
    wr(focvr_pkg::A_OUT_ANGLE, 16'hC000);
    rdc("out_angle_wr", focvr_pkg::A_OUT_ANGLE, 16'hC000);
    wr(focvr_pkg::A_EST_SPEED, 16'h7FFF);
    rdc("est_speed", focvr_pkg::A_EST_SPEED, 16'h7FFF);
    $display("compensation test done");
  endtask
  task t_peak();
    eng_i.phase_a <= 16'h0700;
    tick();
    eng_i.phase_a <= 16'h0200;
    tick();
    rdc("peak", focvr_pkg::A_PHASE_A_PEAK, 16'h0700);
    @(posedge clk_i);
    peak_clear_i <= 1'b1;
    @(posedge clk_i);
    peak_clear_i <= 1'b0;
    rdc("peak_clr", focvr_pkg::A_PHASE_A_PEAK, 16'h0000);
    $display("peak test done");
  endtask
  task t_fg();
    eng_i.est_speed <= 16'h4000;
    tick();
    no_load("fg_off");
    wr(focvr_pkg::A_SPEED_FILT, 16'h00FF);
    tick();
    chk("filt_speed", drv_o.filt_speed, 16'h007F);
    wr(focvr_pkg::A_FREQ_COEFF, 16'h007F);
    tick();
    wait_load();
    chk("reload", drv_o.timer4_reload, 16'h0100);
    chk("compare", drv_o.timer4_compare, 16'h0080);
    chk("fg_ovf", 16'(drv_o.fg_overflow), 16'h0000);
    wr(focvr_pkg::A_FREQ_COEFF, 16'hFFFF);
    tick();
    wait_load();
    chk("reload_sat", drv_o.timer4_reload, 16'hFFFF);
    chk("compare_sat", drv_o.timer4_compare, 16'h7FFF);
    chk("fg_ovf_sat", 16'(drv_o.fg_overflow), 16'h0001);
    wr(focvr_pkg::A_FREQ_COEFF, 16'h0000);
    tick();
    no_load("fg_off_again");
    $display("frequency output test done");
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    rdc("rst_peak", focvr_pkg::A_PHASE_A_PEAK, focvr_pkg::RST_WORD);
    t_ro();
    t_comp();
    t_peak();
    t_fg();
    give_verdict();
  end
endmodule
